/* File: src/aopd_pkg.sv */
// Package for the alarm output pulse driver: register map, fields, reset values, timing
// Operation
// - A polarity setting selects high or low as the asserted alarm level.
// - High-active polarity: output idles low, goes high on alarm.
// - Low-active polarity: output idles high, goes low on alarm.
// - Default settings select high-active polarity.
// - Steady mode holds the output asserted for the whole alarm condition.
// - Pulsed mode toggles asserted and idle while the alarm condition lasts.
// - Default settings select pulsed mode, not steady.
// - Each pulse lasts the on-duration, default five seconds.
// - Each pulse is followed by idle for the off-duration, default five seconds.
package aopd_pkg;

   localparam int          APB_AW          = 12;
   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL       = 12'h000;
   localparam logic [11:0] ADDR_TON        = 12'h004;
   localparam logic [11:0] ADDR_TOFF       = 12'h008;
   localparam logic [11:0] ADDR_STATUS     = 12'h00C;
   // Control fields
   localparam int          CTRL_LOW_ACT    = 0;
   localparam int          CTRL_STEADY     = 1;
   localparam int          CTRL_DEFAULTS   = 2;
   // Status fields
   localparam int          STAT_COND       = 0;
   localparam int          STAT_OUT_ACT    = 1;
   localparam int          STAT_ON_PHASE   = 2;
   // Durations are programmed in milliseconds
   localparam int          DUR_W           = 16;
   localparam logic [15:0] TON_RESET_MS    = 16'h1388;
   localparam logic [15:0] TOFF_RESET_MS   = 16'h1388;
   localparam int          CLK_HZ          = 50_000_000;
   localparam int          MS_PER_S        = 1000;
   localparam int          CYC_PER_MS      = CLK_HZ / MS_PER_S;
   localparam int          MS_CNT_W        = 16;

   typedef struct packed
   {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [APB_AW-1:0] paddr;
      logic [31:0]       pwdata;
   } aopd_apb_req_t;

   typedef struct packed
   {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } aopd_apb_rsp_t;

   typedef enum logic [1:0] {AOPD_IDLE, AOPD_ON, AOPD_OFF} aopd_state_t;

endpackage : aopd_pkg

/* File: src/aopd_top.sv */
// Alarm output pulse driver with APB configuration registers
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module aopd_top
#(
   parameter int CYC_MS = aopd_pkg::CYC_PER_MS
)
(
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   input  wire logic                    ce_i,
   input  wire logic                    alarm_cond_i,
   input  wire aopd_pkg::aopd_apb_req_t apb_req_i,
   output      aopd_pkg::aopd_apb_rsp_t apb_rsp_o,
   output      logic                    alarm_o
);
   import aopd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////
   // Condition synchroniser; the first stage feeds only the second
   logic cond_s1;
   logic cond;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cond_s1 <= 1'b0;
         cond    <= 1'b0;
      end
      else if (ce_i)
      begin
         cond_s1 <= alarm_cond_i;
         cond    <= cond_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // APB register file
   logic             low_active;
   logic             steady_alarm_mode;
   logic [DUR_W-1:0] ton_ms;
   logic [DUR_W-1:0] toff_ms;
   aopd_state_t      state;

   wire acc      = apb_req_i.psel && apb_req_i.penable;
   wire wr       = acc && apb_req_i.pwrite;
   wire sel_ctrl = apb_req_i.paddr == ADDR_CTRL;
   wire sel_ton  = apb_req_i.paddr == ADDR_TON;
   wire sel_toff = apb_req_i.paddr == ADDR_TOFF;
   wire sel_stat = apb_req_i.paddr == ADDR_STATUS;
   wire mapped   = sel_ctrl || sel_ton || sel_toff || sel_stat;
   // Restore commits at the pready edge only, like every other write
   wire defaults = wr && apb_rsp_o.pready && sel_ctrl && apb_req_i.pwdata[CTRL_DEFAULTS];

   wire [31:0] rd_ctrl = {30'h0, steady_alarm_mode, low_active};
   wire [31:0] rd_stat = {29'h0, state == AOPD_ON, alarm_o ^ low_active, cond};
   wire [31:0] rd_mux  = sel_ctrl ? rd_ctrl :
                         sel_ton  ? {16'h0, ton_ms} :
                         sel_toff ? {16'h0, toff_ms} :
                         sel_stat ? rd_stat : 32'h0;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         low_active        <= 1'b0;
         steady_alarm_mode <= 1'b0;
         ton_ms            <= TON_RESET_MS;
         toff_ms           <= TOFF_RESET_MS;
         apb_rsp_o         <= '0;
      end
      else if (ce_i)
      begin
         // Slave answers one cycle into the access phase
         apb_rsp_o.pready  <= acc && !apb_rsp_o.pready;
         apb_rsp_o.pslverr <= acc && !apb_rsp_o.pready && !mapped;
         apb_rsp_o.prdata  <= (acc && !apb_req_i.pwrite) ? rd_mux : 32'h0;
         if (defaults)
         begin
            low_active        <= 1'b0;
            steady_alarm_mode <= 1'b0;
            ton_ms            <= TON_RESET_MS;
            toff_ms           <= TOFF_RESET_MS;
         end
         else if (wr && apb_rsp_o.pready)
         begin
            if (sel_ctrl)
            begin
               low_active        <= apb_req_i.pwdata[CTRL_LOW_ACT];
               steady_alarm_mode <= apb_req_i.pwdata[CTRL_STEADY];
            end
            if (sel_ton)
               ton_ms <= apb_req_i.pwdata[DUR_W-1:0];
            if (sel_toff)
               toff_ms <= apb_req_i.pwdata[DUR_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Phase timer: millisecond prescaler plus millisecond counter
   logic [MS_CNT_W-1:0] pre;
   logic [DUR_W-1:0]    ms;
   aopd_state_t         next_state;

   wire ms_tick  = pre == MS_CNT_W'(CYC_MS - 1);
   // A zero duration is treated as one millisecond so pulsing never stalls
   wire on_done  = ms_tick && (ms + 16'h0001 >= ton_ms);
   wire off_done = ms_tick && (ms + 16'h0001 >= toff_ms);

   always_comb
   begin
      next_state = state;
      case (state)
         AOPD_IDLE : if (cond) next_state = AOPD_ON;
         AOPD_ON   :
            if (!cond)
               next_state = AOPD_IDLE;
            else if (!steady_alarm_mode && on_done)
               next_state = AOPD_OFF;
         AOPD_OFF  :
            if (!cond)
               next_state = AOPD_IDLE;
            else if (steady_alarm_mode || off_done)
               next_state = AOPD_ON;
         default   : next_state = AOPD_IDLE;
      endcase
   end

   wire phase_chg = next_state != state;
   wire next_act  = next_state == AOPD_ON;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state   <= AOPD_IDLE;
         pre     <= '0;
         ms      <= '0;
         alarm_o <= 1'b0;
      end
      else if (ce_i)
      begin
         state   <= next_state;
         pre     <= (phase_chg || ms_tick) ? '0 : pre + 1'b1;
         ms      <= phase_chg ? '0 : (ms_tick ? ms + 1'b1 : ms);
         alarm_o <= next_act ^ low_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_idle_level;
      (ce_i && $past(ce_i) && state == AOPD_IDLE && $past(state) == AOPD_IDLE
         && $stable(low_active))
         |-> alarm_o == low_active;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

   property p_on_level;
      (state == AOPD_ON && $past(state) == AOPD_ON && $stable(low_active))
         |-> alarm_o == !low_active;
   endproperty
   a_on_level: assert property (p_on_level) else $error("on level wrong");

   property p_start_on;
      (ce_i && state == AOPD_IDLE && cond) |=> state == AOPD_ON;
   endproperty
   a_start_on: assert property (p_start_on) else $error("pulse not started on");

   property p_end_idle;
      (ce_i && !cond) |=> state == AOPD_IDLE;
   endproperty
   a_end_idle: assert property (p_end_idle) else $error("no idle after end");

   property p_steady;
      (ce_i && steady_alarm_mode && state == AOPD_ON && cond) |=> state != AOPD_OFF;
   endproperty
   a_steady: assert property (p_steady) else $error("steady mode pulsed");

   property p_on_end;
      (ce_i && state == AOPD_ON && cond && !steady_alarm_mode && on_done)
         |=> state == AOPD_OFF;
   endproperty
   a_on_end: assert property (p_on_end) else $error("on phase overran");

   property p_on_len;
      // Steady mode keeps the on phase open, so the length bound does not apply
      (state == AOPD_ON && $past(state) == AOPD_ON && !steady_alarm_mode)
         |-> ms < ton_ms || ton_ms == '0;
   endproperty
   a_on_len: assert property (p_on_len) else $error("on phase too long");

   property p_off_len;
      (state == AOPD_OFF && $past(state) == AOPD_OFF) |-> ms < toff_ms || toff_ms == '0;
   endproperty
   a_off_len: assert property (p_off_len) else $error("off phase too long");

   property p_defaults;
      (ce_i && defaults) |=> !low_active && !steady_alarm_mode && ton_ms == TON_RESET_MS;
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults wrong");

   property p_pol_write;
      (ce_i && wr && apb_rsp_o.pready && sel_ctrl && !defaults)
         |=> low_active == $past(apb_req_i.pwdata[CTRL_LOW_ACT]);
   endproperty
   a_pol_write: assert property (p_pol_write) else $error("polarity not stored");

   c_pulse_off:  cover property (state == AOPD_ON ##1 state == AOPD_OFF);
   c_pulse_back: cover property (state == AOPD_OFF ##1 state == AOPD_ON);
   c_low_alarm:  cover property (low_active && state == AOPD_ON);
   c_steady_on:  cover property (steady_alarm_mode && state == AOPD_ON);

endmodule : aopd_top

/* File: tb/aopd_siren_model.sv */
// Far-side siren model: measures how long the alarm line sounds and rests
`timescale 1ns/1ps
module aopd_siren_model
(
   input  wire logic        clk_i,
   input  wire logic        line_i,
   input  wire logic        high_act_i,
   output      logic [15:0] on_len_o,
   output      logic [15:0] off_len_o
);
   logic [15:0] run  = 16'h0000;
   logic        prev = 1'b0;
   wire         sounding = (line_i == high_act_i);

   // A run is stored when the level flips, so a stuck line never updates a length
   always_ff @(posedge clk_i)
   begin
      prev <= sounding;
      if (sounding != prev)
      begin
         if (prev)
            on_len_o <= run;
         else
            off_len_o <= run;
         run <= 16'h0001;
      end
      else
         run <= run + 16'h0001;
   end
endmodule : aopd_siren_model

/* File: tb/tb_alarm_output_pulse_driver.sv */
// Self-checking bench for the alarm output pulse driver
`timescale 1ns/1ps
module tb_alarm_output_pulse_driver;
   import aopd_pkg::*;
   // Four cycles a millisecond keeps pulse trains short
   localparam int CYC = 4;
   logic          clk_i    = 1'b0;
   logic          nrst_i   = 1'b0;
   logic          cond     = 1'b0;
   logic          high_act = 1'b1;
   aopd_apb_req_t req      = '0;
   aopd_apb_rsp_t rsp;
   logic          alarm_o;
   logic [15:0]   on_len;
   logic [15:0]   off_len;
   logic [31:0]   rd;
   logic          err;
   int            bad_count = 0;
   int            tests_run = 0;

   aopd_top #(.CYC_MS(CYC)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .alarm_cond_i(cond), .apb_req_i(req), .apb_rsp_o(rsp), .alarm_o(alarm_o));
   aopd_siren_model siren (.clk_i(clk_i), .line_i(alarm_o), .high_act_i(high_act),
      .on_len_o(on_len), .off_len_o(off_len));

   initial forever #10 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", name, e, g);
         bad_count++;
      end
   endtask : chk

   // Request held until pready is sampled high; data taken at that edge only
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge clk_i);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, rsp.pready});
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      // One idle edge so a following call never reassigns req in this time step
      @(posedge clk_i);
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd, err);
      chk("prdata", e, rd);
   endtask : rd_chk

   task automatic wait_pin(input logic v, input int lim);
      int n;
      n = 0;
      while (alarm_o !== v && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("alarm_o", {31'h0, v}, {31'h0, alarm_o});
   endtask : wait_pin
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      chk("idle", 32'h0, {31'h0, alarm_o});
      rd_chk(ADDR_CTRL, 32'h0);
      rd_chk(ADDR_TON, 32'h1388);
      rd_chk(ADDR_TOFF, 32'h1388);
      apb(1'b0, 12'h010, 32'h0, rd, err);
      chk("pslverr", 32'h1, {31'h0, err});
   endtask : t_defaults

   task automatic t_pulse();
      apb(1'b1, ADDR_TON, 32'h2, rd, err);
      apb(1'b1, ADDR_TOFF, 32'h3, rd, err);
      cond <= 1'b1;
      wait_pin(1'b1, 6);
      wait_pin(1'b0, 2 * CYC + 4);
      repeat (2) @(posedge clk_i);
      chk("on_len", 32'(2 * CYC), {16'h0, on_len});
      wait_pin(1'b1, 3 * CYC + 4);
      repeat (2) @(posedge clk_i);
      chk("off_len", 32'(3 * CYC), {16'h0, off_len});
      // Drop the condition mid-pulse: the pin must not finish the on phase
      cond <= 1'b0;
      wait_pin(1'b0, 5);
   endtask : t_pulse

   task automatic t_low_steady();
      high_act <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h3, rd, err);
      wait_pin(1'b1, 3);
      cond <= 1'b1;
      wait_pin(1'b0, 6);
      // Far longer than the programmed on time, so a pulse would show
      repeat (40)
      begin
         @(posedge clk_i);
         chk("steady", 32'h0, {31'h0, alarm_o});
      end
      // Status: condition seen, output asserted, on phase held
      rd_chk(ADDR_STATUS, 32'h7);
      cond <= 1'b0;
      wait_pin(1'b1, 5);
   endtask : t_low_steady

   task automatic t_restore();
      apb(1'b1, ADDR_CTRL, 32'h4, rd, err);
      high_act <= 1'b1;
      rd_chk(ADDR_CTRL, 32'h0);
      rd_chk(ADDR_TON, 32'h1388);
      wait_pin(1'b0, 3);
   endtask : t_restore
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   initial
   begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      t_defaults();
      t_pulse();
      t_low_steady();
      t_restore();
      print_verdict();
   end

   initial
   begin
      #(20 * 5000);
      bad_count++;
      print_verdict();
   end
endmodule : tb_alarm_output_pulse_driver
